// File: design/fcs_array.sv
/*
  Storage array of the flash: program clears bits, erase sets a byte.
  Assumes one write per cycle and that the core never programs and
  erases at once.
*/
`timescale 1ns/1ps
module fcs_array #(
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  fcs_mem_if.array mem
);
  logic [7:0] cell_r [2**AW];

  // Programming only clears bits, as real cells do
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      for (int i = 0; i < 2**AW; i++)
        cell_r[i] <= fcs_pkg::ERASED_BYTE;
    end
    else if (mem.prog)
      cell_r[mem.wr_addr] <= cell_r[mem.wr_addr] & mem.wr_data;
    else if (mem.erase)
      cell_r[mem.wr_addr] <= fcs_pkg::ERASED_BYTE;

  assign mem.rd_data = cell_r[mem.rd_addr];
endmodule

// File: design/fcs_if.sv
/*
  Carriers between the sequencer core and its two helpers: the serial
  link byte path and the storage array port.
  Assumes the core owns all writes to the array.
*/
`timescale 1ns/1ps
interface fcs_link_if;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic [7:0] tx_byte;
  modport link (output rx_byte, output rx_tgl, input tx_byte);
  modport core (input rx_byte, input rx_tgl, output tx_byte);
endinterface

interface fcs_mem_if #(parameter int AW = 8);
  logic prog;
  logic erase;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport array (input prog, input erase, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
  modport core (output prog, output erase, output wr_addr,
    output wr_data, output rd_addr, input rd_data);
endinterface

// File: design/fcs_pkg.sv
/*
  Shared constants of the serial flash command sequencer: opcodes,
  status field layout, timing counts and the decoder state type.
  Assumes a 125 MHz core clock.
*/
package fcs_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS = 800;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_TIME_NS = 1600;
  localparam int ERASE_CYCLES =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 16;
  localparam int ADDR_BYTES = 3;
  localparam int ADDR_BITS = 24;

  localparam logic [7:0] WRITE_STATUS_COMMAND = 8'h01;
  localparam logic [7:0] PAGE_PROGRAM_COMMAND = 8'h02;
  localparam logic [7:0] READ_ARRAY_COMMAND = 8'h03;
  localparam logic [7:0] WRITE_LOCK_COMMAND = 8'h04;
  localparam logic [7:0] READ_STATUS_COMMAND = 8'h05;
  localparam logic [7:0] WRITE_UNLOCK_COMMAND = 8'h06;
  localparam logic [7:0] READ_FAST_COMMAND = 8'h0B;
  localparam logic [7:0] STATUS_WRITE_ENABLE_COMMAND = 8'h50;
  localparam logic [7:0] READ_IDENT_COMMAND = 8'h9F;
  localparam logic [7:0] WAKE_SIGNATURE_COMMAND = 8'hAB;
  localparam logic [7:0] DEEP_SLEEP_ENTER_COMMAND = 8'hB9;
  localparam logic [7:0] WHOLE_ARRAY_WIPE_COMMAND = 8'hC7;
  localparam logic [7:0] PARTIAL_WIPE_COMMAND = 8'hD8;

  localparam int SR_WR_DISABLE = 7;
  localparam int SR_RSVD_HI = 6;
  localparam int SR_RSVD_LO = 5;
  localparam int SR_PROT_HI = 4;
  localparam int SR_PROT_LO = 2;
  localparam int SR_WR_LATCH = 1;
  localparam int SR_BUSY = 0;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } fcs_state_t;
endpackage

// File: design/fcs_spi_link.sv
/*
  Serial link end in the serial clock domain: shifts bytes in on the
  rising edge, shifts the answer out on the falling edge.
  Assumes mode 0 and that the core settles tx_byte within half a
  serial clock period of each byte toggle.
*/
`timescale 1ns/1ps
module fcs_spi_link (
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic rst_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  fcs_link_if.link lk
);
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic rx_tgl_r;
  logic [7:0] tx_sh_r;

  // Deselect restarts the bit count, so a short frame never skews the next
  always_ff @(posedge sck_i or posedge cs_n_i)
    if (cs_n_i)
    begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= {rx_sh_r[5:0], mosi_i};
    end

  // Toggle carries the byte event; the byte stays put for a whole byte
  always_ff @(posedge sck_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      rx_byte_r <= 8'h00;
      rx_tgl_r <= 1'b0;
    end
    else if (!cs_n_i && bit_cnt_r == 3'h7)
    begin
      rx_byte_r <= {rx_sh_r, mosi_i};
      rx_tgl_r <= ~rx_tgl_r;
    end

  always_ff @(negedge sck_i or posedge cs_n_i)
    if (cs_n_i)
    begin
      tx_sh_r <= fcs_pkg::ERASED_BYTE;
      miso_oe_o <= 1'b0;
    end
    else
    begin
      miso_oe_o <= 1'b1;
      tx_sh_r <= (bit_cnt_r == 3'h0) ? lk.tx_byte : {tx_sh_r[6:0], 1'b1};
    end

  assign miso_o = tx_sh_r[7];
  assign lk.rx_byte = rx_byte_r;
  assign lk.rx_tgl = rx_tgl_r;
endmodule

// File: design/fcs_top.sv
/*
  Serial flash command sequencer: decodes framed commands, keeps the
  status byte, drives program, erase, sleep, signature and ident.
  Assumes a single master that frames each command with chip select.
*/
`timescale 1ns/1ps
module fcs_top #(
  parameter int ADDR_W = 8,
  parameter int PAGE_W = 4,
  parameter int SECT_W = 6,
  // Arbitrary identity values
  parameter logic [7:0] SIGNATURE = 8'h3C,
  parameter logic [7:0] MAKER_CODE = 8'hC3,
  parameter logic [15:0] PART_CODE = 16'h7E21
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic SPI_SCK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O
);
  localparam int NSECT = 2 ** (ADDR_W - SECT_W);
  localparam int AB = fcs_pkg::ADDR_BITS;

  fcs_link_if lk ();
  fcs_mem_if #(.AW(ADDR_W)) mem ();

  fcs_spi_link u_link (
    .sck_i(SPI_SCK_I),
    .cs_n_i(SPI_CS_N_I),
    .rst_n_i(RST_N_I),
    .mosi_i(SPI_MOSI_I),
    .miso_o(SPI_MISO_O),
    .miso_oe_o(SPI_MISO_OE_O),
    .lk(lk.link)
  );

  fcs_array #(.AW(ADDR_W)) u_array (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .mem(mem.array)
  );

  // Top sectors are protected: one at level 1, doubling with each step up to all sectors
  function automatic logic is_prot(input logic [ADDR_W-1:0] a,
                                   input logic [2:0] lvl);
    int cnt;
    cnt = (lvl == 3'h0) ? 0 : (1 << (lvl - 3'h1));
    if (cnt > NSECT)
      cnt = NSECT;
    return (int'(a >> SECT_W) >= NSECT - cnt);
  endfunction

  logic cs_meta_r, cs_sync_r, cs_prev_r;
  logic tg_meta_r, tg_sync_r, tg_prev_r;
  fcs_pkg::fcs_state_t st_r, st_nxt;
  logic [7:0] op_r;
  logic op_valid_r;
  logic [1:0] acnt_r;
  logic [AB-1:0] addr_r;
  logic [1:0] idx_r;
  logic [7:0] sr_new_r;
  logic sr_pend_r;
  logic prog_seen_r;
  logic [7:0] tx_r, tx_sel, status_byte;
  logic write_enable_latch_r, status_wr_armed_r;
  logic status_write_disable_r;
  logic [2:0] protect_level_r;
  logic dpd_r;
  logic [fcs_pkg::BUSY_W-1:0] busy_cnt_r;
  logic erase_on_r;
  logic [ADDR_W-1:0] erase_ptr_r, erase_end_r;

  // Chip select and byte toggle cross on two flops each
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      {cs_meta_r, cs_sync_r, cs_prev_r} <= 3'h7;
      {tg_meta_r, tg_sync_r, tg_prev_r} <= 3'h0;
    end
    else
    begin
      {cs_meta_r, cs_sync_r, cs_prev_r} <= {SPI_CS_N_I, cs_meta_r, cs_sync_r};
      {tg_meta_r, tg_sync_r, tg_prev_r} <= {lk.rx_tgl, tg_meta_r, tg_sync_r};
    end

  wire [7:0] rx = lk.rx_byte;
  wire byte_ev = tg_sync_r ^ tg_prev_r;
  wire frame_end = cs_sync_r & ~cs_prev_r;
  wire program_erase_in_progress = (busy_cnt_r != '0) | erase_on_r;
  wire op_ev = byte_ev & (st_r == fcs_pkg::ST_OPCODE);
  wire data_ev = byte_ev & (st_r == fcs_pkg::ST_DATA) & op_valid_r;
  wire known = rx inside {fcs_pkg::WRITE_STATUS_COMMAND,
    fcs_pkg::PAGE_PROGRAM_COMMAND, fcs_pkg::READ_ARRAY_COMMAND,
    fcs_pkg::WRITE_LOCK_COMMAND, fcs_pkg::READ_STATUS_COMMAND,
    fcs_pkg::WRITE_UNLOCK_COMMAND, fcs_pkg::READ_FAST_COMMAND,
    fcs_pkg::STATUS_WRITE_ENABLE_COMMAND, fcs_pkg::READ_IDENT_COMMAND,
    fcs_pkg::WAKE_SIGNATURE_COMMAND, fcs_pkg::DEEP_SLEEP_ENTER_COMMAND,
    fcs_pkg::WHOLE_ARRAY_WIPE_COMMAND, fcs_pkg::PARTIAL_WIPE_COMMAND};
  // Asleep only the wake command counts; busy only the status read
  wire op_accept = dpd_r ? (rx == fcs_pkg::WAKE_SIGNATURE_COMMAND) :
    program_erase_in_progress ? (rx == fcs_pkg::READ_STATUS_COMMAND) :
    known;
  wire needs_addr = rx inside {fcs_pkg::READ_ARRAY_COMMAND,
    fcs_pkg::READ_FAST_COMMAND, fcs_pkg::PAGE_PROGRAM_COMMAND,
    fcs_pkg::PARTIAL_WIPE_COMMAND};
  wire last_addr = (acnt_r == 2'(fcs_pkg::ADDR_BYTES - 1));
  wire done_ok = frame_end & op_valid_r;
  wire is_pp = (op_r == fcs_pkg::PAGE_PROGRAM_COMMAND);
  wire [AB-1:0] addr_inc = is_pp ?
    {addr_r[AB-1:PAGE_W], addr_r[PAGE_W-1:0] + 1'b1} :
    addr_r + 24'h00_0001;
  wire prog_en = data_ev & is_pp & write_enable_latch_r &
    !is_prot(addr_r[ADDR_W-1:0], protect_level_r);
  wire prog_go = done_ok & is_pp & write_enable_latch_r & prog_seen_r;
  wire write_status_command_go = done_ok & (op_r == fcs_pkg::WRITE_STATUS_COMMAND) &
    sr_pend_r & (write_enable_latch_r | status_wr_armed_r);
  wire sect_go = done_ok & (op_r == fcs_pkg::PARTIAL_WIPE_COMMAND) &
    write_enable_latch_r & (st_r == fcs_pkg::ST_DATA);
  wire bulk_go = done_ok & (op_r == fcs_pkg::WHOLE_ARRAY_WIPE_COMMAND) &
    write_enable_latch_r & (protect_level_r == 3'h0);
  wire erase_go = sect_go | bulk_go;
  wire latch_clr = (done_ok & (op_r == fcs_pkg::WRITE_LOCK_COMMAND)) |
    write_status_command_go | prog_go | erase_go;
  wire [ADDR_W-1:0] erase_from = sect_go ?
    {addr_r[ADDR_W-1:SECT_W], SECT_W'(0)} : '0;
  wire [ADDR_W-1:0] erase_to = sect_go ?
    {addr_r[ADDR_W-1:SECT_W], {SECT_W{1'b1}}} : '1;

  assign mem.prog = prog_en;
  assign mem.erase = erase_on_r & !is_prot(erase_ptr_r, protect_level_r);
  assign mem.wr_addr = erase_on_r ? erase_ptr_r : addr_r[ADDR_W-1:0];
  assign mem.wr_data = rx;
  assign mem.rd_addr = addr_r[ADDR_W-1:0];
  assign lk.tx_byte = tx_r;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[fcs_pkg::SR_RSVD_HI:fcs_pkg::SR_RSVD_LO] = 2'h0;
    status_byte[fcs_pkg::SR_WR_DISABLE] = status_write_disable_r;
    status_byte[fcs_pkg::SR_PROT_HI:fcs_pkg::SR_PROT_LO] =
      protect_level_r;
    status_byte[fcs_pkg::SR_WR_LATCH] = write_enable_latch_r;
    status_byte[fcs_pkg::SR_BUSY] = program_erase_in_progress;
  end

  always_comb
  begin
    case (op_r)
      fcs_pkg::READ_STATUS_COMMAND: tx_sel = status_byte;
      fcs_pkg::READ_ARRAY_COMMAND,
      fcs_pkg::READ_FAST_COMMAND: tx_sel = mem.rd_data;
      fcs_pkg::WAKE_SIGNATURE_COMMAND: tx_sel = SIGNATURE;
      fcs_pkg::READ_IDENT_COMMAND:
        tx_sel = (idx_r == 2'h0) ? MAKER_CODE :
                 (idx_r == 2'h1) ? PART_CODE[15:8] :
                 (idx_r == 2'h2) ? PART_CODE[7:0] : fcs_pkg::ERASED_BYTE;
      default: tx_sel = fcs_pkg::ERASED_BYTE;
    endcase
    if (!op_valid_r)
      tx_sel = fcs_pkg::ERASED_BYTE;
  end

  always_comb
  begin
    st_nxt = st_r;
    if (frame_end)
      st_nxt = fcs_pkg::ST_OPCODE;
    else if (byte_ev)
      case (st_r)
        fcs_pkg::ST_OPCODE:
          st_nxt = !op_accept ? fcs_pkg::ST_IGNORE :
                   needs_addr ? fcs_pkg::ST_ADDR : fcs_pkg::ST_DATA;
        fcs_pkg::ST_ADDR:
          if (last_addr)
            st_nxt = (op_r == fcs_pkg::READ_FAST_COMMAND) ?
                     fcs_pkg::ST_DUMMY : fcs_pkg::ST_DATA;
        fcs_pkg::ST_DUMMY: st_nxt = fcs_pkg::ST_DATA;
        default: st_nxt = st_r;
      endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      st_r <= fcs_pkg::ST_OPCODE;
      op_r <= 8'h00;
      op_valid_r <= 1'b0;
      tx_r <= fcs_pkg::ERASED_BYTE;
    end
    else
    begin
      st_r <= st_nxt;
      tx_r <= tx_sel;
      if (op_ev)
        op_r <= rx;
      if (frame_end)
        op_valid_r <= 1'b0;
      else if (op_ev)
        op_valid_r <= op_accept;
    end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      acnt_r <= 2'h0;
      addr_r <= '0;
      idx_r <= 2'h0;
    end
    else if (op_ev)
    begin
      acnt_r <= 2'h0;
      idx_r <= 2'h0;
    end
    else if (byte_ev && st_r == fcs_pkg::ST_ADDR)
    begin
      acnt_r <= acnt_r + 2'h1;
      addr_r <= {addr_r[AB-9:0], rx};
    end
    else if (data_ev)
    begin
      addr_r <= addr_inc;
      if (idx_r != 2'h3)
        idx_r <= idx_r + 2'h1;
    end

  // Only the first data byte of a status write counts
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      sr_new_r <= 8'h00;
      sr_pend_r <= 1'b0;
      prog_seen_r <= 1'b0;
    end
    else if (frame_end)
    begin
      sr_pend_r <= 1'b0;
      prog_seen_r <= 1'b0;
    end
    else if (data_ev)
    begin
      if (op_r == fcs_pkg::WRITE_STATUS_COMMAND && !sr_pend_r)
      begin
        sr_new_r <= rx;
        sr_pend_r <= 1'b1;
      end
      if (is_pp)
        prog_seen_r <= 1'b1;
    end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      write_enable_latch_r <= 1'b0;
      status_wr_armed_r <= 1'b0;
      status_write_disable_r <= 1'b0;
      protect_level_r <= 3'h0;
      dpd_r <= 1'b0;
    end
    else
    begin
      if (done_ok && op_r == fcs_pkg::WRITE_UNLOCK_COMMAND)
        write_enable_latch_r <= 1'b1;
      else if (latch_clr)
        write_enable_latch_r <= 1'b0;
      if (done_ok && op_r == fcs_pkg::STATUS_WRITE_ENABLE_COMMAND)
        status_wr_armed_r <= 1'b1;
      else if (latch_clr)
        status_wr_armed_r <= 1'b0;
      if (write_status_command_go)
      begin
        status_write_disable_r <= sr_new_r[fcs_pkg::SR_WR_DISABLE];
        if (!status_write_disable_r)
          protect_level_r <=
            sr_new_r[fcs_pkg::SR_PROT_HI:fcs_pkg::SR_PROT_LO];
      end
      if (op_ev && op_accept && rx == fcs_pkg::WAKE_SIGNATURE_COMMAND)
        dpd_r <= 1'b0;
      else if (done_ok && op_r == fcs_pkg::DEEP_SLEEP_ENTER_COMMAND)
        dpd_r <= 1'b1;
    end

  // Erase walks one byte per cycle so protected bytes can be skipped
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      busy_cnt_r <= '0;
      erase_on_r <= 1'b0;
      erase_ptr_r <= '0;
      erase_end_r <= '0;
    end
    else
    begin
      if (prog_go)
        busy_cnt_r <= fcs_pkg::BUSY_W'(fcs_pkg::PROG_CYCLES);
      else if (erase_go)
        busy_cnt_r <= fcs_pkg::BUSY_W'(fcs_pkg::ERASE_CYCLES);
      else if (busy_cnt_r != '0)
        busy_cnt_r <= busy_cnt_r - 1'b1;
      if (erase_go)
      begin
        erase_on_r <= 1'b1;
        erase_ptr_r <= erase_from;
        erase_end_r <= erase_to;
      end
      else if (erase_on_r)
      begin
        erase_ptr_r <= erase_ptr_r + ADDR_W'(1);
        if (erase_ptr_r == erase_end_r)
          erase_on_r <= 1'b0;
      end
    end

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence wake_taken_s;
    op_ev && op_accept && rx == fcs_pkg::WAKE_SIGNATURE_COMMAND;
  endsequence
  sequence sleep_done_s;
    done_ok && op_r == fcs_pkg::DEEP_SLEEP_ENTER_COMMAND;
  endsequence

  disable_lock_a:
    assert property (status_write_disable_r |=> $stable(protect_level_r))
    else $error("protect bits changed while write disable set");
  status_reply_a:
    assert property (op_valid_r && op_r == fcs_pkg::READ_STATUS_COMMAND
      |=> tx_r == $past(status_byte) && tx_r[6:5] == 2'h0)
    else $error("status reply wrong");
  status_mask_a:
    assert property (write_status_command_go |=> status_write_disable_r ==
      $past(sr_new_r[fcs_pkg::SR_WR_DISABLE]) && !write_enable_latch_r)
    else $error("status write result wrong");
  prog_busy_a:
    assert property (prog_go |=> status_byte[fcs_pkg::SR_BUSY] [*8])
    else $error("busy flag not held after program start");
  prot_prog_a:
    assert property (mem.prog |->
      !is_prot(mem.wr_addr, protect_level_r) && write_enable_latch_r)
    else $error("protected byte programmed");
  read_step_a:
    assert property (data_ev && op_r == fcs_pkg::READ_ARRAY_COMMAND
      |=> addr_r == $past(addr_r) + 24'h00_0001)
    else $error("read address did not advance");
  bulk_guard_a:
    assert property (done_ok && protect_level_r != 3'h0 &&
      op_r == fcs_pkg::WHOLE_ARRAY_WIPE_COMMAND && !erase_on_r
      |=> !erase_on_r)
    else $error("whole wipe ran under protection");
  erase_skip_a:
    assert property (mem.erase |-> !is_prot(mem.wr_addr, protect_level_r))
    else $error("protected byte erased");
  sleep_enter_a:
    assert property (sleep_done_s |=> dpd_r ##1 dpd_r)
    else $error("deep sleep not entered");
  wake_sig_a:
    assert property (wake_taken_s |=> !dpd_r ##1 tx_r == SIGNATURE)
    else $error("signature not presented after wake");
  unlock_set_a:
    assert property (done_ok && op_r == fcs_pkg::WRITE_UNLOCK_COMMAND
      |=> write_enable_latch_r)
    else $error("write unlock did not set latch");
  lock_clear_a:
    assert property (done_ok && op_r == fcs_pkg::WRITE_LOCK_COMMAND
      |=> !write_enable_latch_r)
    else $error("write lock did not clear latch");
endmodule

// File: tb/fcs_master.sv
/*
  Serial master model for the flash sequencer bench: mode 0 frames,
  one command per chip-select low period.
  Assumes the bench calls frame() from one process at a time.
*/
`timescale 1ns/1ps
module fcs_master (
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Clock stands low between frames; 80 ns period inside a frame
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n_o = 1'b0;
    #40;
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        mosi_o = tx[i][k];
        #40;
        sck_o = 1'b1;
        b[k] = miso_i;
        #40;
        sck_o = 1'b0;
      end
      rx.push_back(b);
    end
    #40;
    cs_n_o = 1'b1;
    // Released data line must not keep looking valid
    mosi_o = ~mosi_o;
    #64;
  endtask
endmodule

// File: tb/fcs_top_tb_top.sv
/*
  Self-checking bench for the flash command sequencer: commands are
  framed by the master model and answers compared with expectations.
  Assumes the sequencer's chosen opcodes and a 256 byte array.
*/
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("BAD %0t: got %h expected %h", $time, a, e); \
    end \
  end

module fcs_top_tb_top;
  // Arbitrary identity values
  localparam logic [7:0] SIG = 8'h3C;
  localparam logic [7:0] MAKER = 8'hC3;
  localparam logic [15:0] PART = 16'h7E21;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  // Undriven line shows the inverse so no stale value is read
  wire miso_w = miso_oe ? miso : ~miso;
  logic [7:0] rx[$];
  logic [7:0] st;
  int checked = 0;
  int n_mismatch = 0;

  always #4 clk = ~clk;

  fcs_top #(.SIGNATURE(SIG), .MAKER_CODE(MAKER), .PART_CODE(PART)) dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .SPI_SCK_I(sck),
    .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso),
    .SPI_MISO_OE_O(miso_oe));

  // One device on the bus, well inside the two-device limit
  fcs_master m (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso_w));

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic xf(input logic [7:0] q[$]);
    m.frame(q, rx);
  endtask

  task automatic rd_st();
    xf('{8'h05, 8'h00});
    st = rx[1];
  endtask

  // Bounded poll; a sequencer stuck busy ends the run
  task automatic wait_idle();
    for (int n = 0; n < 400; n++)
    begin
      rd_st();
      if (st[0] === 1'b0)
        return;
    end
    n_mismatch++;
    $display("BAD %0t: busy never cleared", $time);
    stop_test();
  endtask

  task automatic wr_st(input logic [7:0] v);
    xf('{8'h50});
    xf('{8'h01, v});
  endtask

  task automatic prog(input logic [7:0] a, input logic [7:0] q[$]);
    logic [7:0] f[$];
    f = {8'h02, 8'h00, 8'h00, a};
    f = {f, q};
    xf('{8'h06});
    xf(f);
  endtask

  task automatic wipe(input logic [7:0] q[$]);
    xf('{8'h06});
    xf(q);
    wait_idle();
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] a, input int n);
    logic [7:0] f[$];
    f = {op, 8'h00, 8'h00, a};
    repeat (n + int'(op == 8'h0B)) f.push_back(8'h00);
    xf(f);
    repeat (4 + int'(op == 8'h0B)) void'(rx.pop_front());
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    $display("BAD %0t: run limit reached", $time);
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd_st();
    `CHK(st, 8'h00)
    `CHK(miso_oe, 1'b0)
    xf('{8'h06});
    rd_st();
    `CHK(st, 8'h02)
    xf('{8'h04});
    rd_st();
    `CHK(st, 8'h00)
    wr_st(8'hFC);
    rd_st();
    `CHK(st & 8'hFC, 8'h9C)
    wr_st(8'h00);
    rd_st();
    `CHK(st & 8'hFC, 8'h1C)
    wr_st(8'h00);
    rd_st();
    `CHK(st & 8'hFC, 8'h00)
    prog(8'h10, '{8'hA5, 8'h3C});
    rd_st();
    `CHK(st[0], 1'b1)
    wait_idle();
    `CHK(st[1], 1'b0)
    // Writes wrap to the page start at the page end; here the wrapped byte goes in a second program
    prog(8'h1F, '{8'h11});
    wait_idle();
    prog(8'h10, '{8'h22});
    wait_idle();
    prog(8'hC0, '{8'h5A});
    wait_idle();
    rd(8'h03, 8'h10, 3);
    `CHK(rx[0], 8'h20)
    `CHK(rx[1], 8'h3C)
    `CHK(rx[2], 8'hFF)
    rd(8'h0B, 8'h1F, 1);
    `CHK(rx[0], 8'h11)
    wr_st(8'h04);
    prog(8'hC0, '{8'h00});
    wait_idle();
    rd(8'h03, 8'hC0, 1);
    `CHK(rx[0], 8'h5A)
    wipe('{8'hD8, 8'h00, 8'h00, 8'hC0});
    rd(8'h03, 8'hC0, 1);
    `CHK(rx[0], 8'h5A)
    wipe('{8'hC7});
    rd(8'h03, 8'h10, 1);
    `CHK(rx[0], 8'h20)
    wr_st(8'h00);
    wipe('{8'hD8, 8'h00, 8'h00, 8'h10});
    rd(8'h03, 8'h10, 1);
    `CHK(rx[0], 8'hFF)
    rd(8'h03, 8'hC0, 1);
    `CHK(rx[0], 8'h5A)
    wipe('{8'hC7});
    rd(8'h03, 8'hC0, 1);
    `CHK(rx[0], 8'hFF)
    xf('{8'h9F, 8'h00, 8'h00, 8'h00});
    `CHK(rx[1], MAKER)
    `CHK(rx[2], PART[15:8])
    `CHK(rx[3], PART[7:0])
    xf('{8'hB9});
    rd_st();
    `CHK(st, 8'hFF)
    xf('{8'hAB, 8'h00});
    `CHK(rx[1], SIG)
    rd_st();
    `CHK(st & 8'hFD, 8'h00)
    `CHK(miso_oe, 1'b0)
    stop_test();
  end
endmodule
